// ===== verification/ldoc_top_tb_top.sv
`default_nettype none
module ldoc_top_tb_top
  import ldoc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic        sys_clk, rst_n;
  logic [11:0] awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [2:0]  lp_req;
  logic        pin_req;
  logic [3:0]  ldo_on, ldo_switch, ldo_discharge;
  logic [19:0] ldo_code;
  logic [47:0] ldo_mv;
  int          n_fail, num_checks;
  logic [31:0] rd;
  logic [1:0]  rs;

  ldoc_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .low_power_request(lp_req), .lowpower_pin_request(pin_req),
    .ldo_on(ldo_on), .ldo_switch(ldo_switch), .ldo_discharge(ldo_discharge),
    .ldo_code(ldo_code), .ldo_mv(ldo_mv));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Bus and check helpers
  // ----------------------------------------------------------------
  function automatic logic [11:0] ba(input logic [9:0] idx);
    return {idx, 2'h0};
  endfunction

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [9:0] idx, input logic [15:0] d, input logic [1:0] er);
    bit aw, w, b;
    int n;
    aw = 0; w = 0; b = 0; n = 0;
    @(posedge sys_clk);
    awaddr <= ba(idx); awvalid <= 1'b1; wdata <= {16'h0000, d}; wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b && n < 50) begin
      @(posedge sys_clk);
      n++;
      if (awready && !aw) begin aw = 1; awvalid <= 1'b0; end
      if (wready && !w) begin w = 1; wvalid <= 1'b0; end
      if (bvalid) begin b = 1; bready <= 1'b0; chk(bresp, er); end
    end
    if (!b) chk(1'b0, 1'b1);
  endtask

  task automatic rdr(input logic [9:0] idx);
    bit a, r;
    int n;
    a = 0; r = 0; n = 0;
    @(posedge sys_clk);
    araddr <= ba(idx); arvalid <= 1'b1; rready <= 1'b1;
    while (!r && n < 50) begin
      @(posedge sys_clk);
      n++;
      if (arready && !a) begin a = 1; arvalid <= 1'b0; end
      if (rvalid) begin r = 1; rready <= 1'b0; rd = rdata; rs = rresp; end
    end
    if (!r) chk(1'b0, 1'b1);
  endtask

  // Outputs follow register effect one edge later
  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  task automatic stop_test();
    $display("checks=%0d failures=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [9:0] img [4] = '{IDX_IMAGE_1, IDX_IMAGE_2, IDX_IMAGE_3, IDX_IMAGE_4};
    chk(ldo_on, 4'h0);
    chk(ldo_discharge, 4'hF);
    foreach (img[i]) begin
      rdr(img[i]);
      chk(rd, 32'h0000001C);
    end
  endtask

  task automatic t_alias();
    wr(IDX_ENABLE_A, 16'h0100, RESP_OK);
    rdr(IDX_ENABLE_B);
    chk(rd, 32'h00000100);
    wr(IDX_ENABLE_B, 16'h0300, RESP_OK);
    rdr(IDX_ENABLE_A);
    chk(rd, 32'h00000300);
    settle();
    chk(ldo_on, 4'h3);
    chk(ldo_mv[11:0], 12'h384);
  endtask

  task automatic t_codes();
    logic [4:0]  c [3] = '{5'h0F, 5'h10, 5'h1F};
    logic [11:0] mv [3] = '{12'h672, 12'h708, 12'hCE4};
    foreach (c[i]) begin
      wr(IDX_MODE_1, {11'h000, c[i]}, RESP_OK);
      settle();
      chk(ldo_code[4:0], c[i]);
      chk(ldo_mv[11:0], mv[i]);
    end
  endtask

  task automatic t_switch();
    wr(IDX_MODE_1, 16'h401F, RESP_OK);
    settle();
    chk(ldo_switch, 4'h1);
    chk(ldo_mv[11:0], 12'h000);
    wr(IDX_MODE_1, 16'h001F, RESP_OK);
    settle();
    chk({ldo_switch[0], ldo_mv[11:0]}, 13'h0CE4);
  endtask

  task automatic t_sleep();
    wr(IDX_SLEEP_CTL, 16'h0001, RESP_OK);
    settle();
    chk(ldo_code[9:0], 10'h39C);
    chk(ldo_mv[11:0], 12'hBB8);
    wr(IDX_SLEEP_CTL, 16'h0000, RESP_OK);
    settle();
    chk(ldo_code[9:0], 10'h01F);
  endtask

  task automatic t_lines();
    for (int s = 1; s <= 3; s++) begin
      wr(IDX_IMAGE_1, 16'h101C | 16'(s << 8), RESP_OK);
      lp_req <= ~(3'h1 << (s - 1));
      settle();
      chk(ldo_on[0], 1'b1);
      @(posedge sys_clk);
      lp_req <= 3'h1 << (s - 1);
      settle();
      chk(ldo_on[0], 1'b0);
      @(posedge sys_clk);
      lp_req <= 3'h0;
      settle();
      chk(ldo_on[0], 1'b1);
    end
  endtask

  task automatic t_pin();
    wr(IDX_IMAGE_1, 16'h031C, RESP_OK);
    pin_req <= 1'b1;
    settle();
    chk(ldo_code[9:0], 10'h39C);
    @(posedge sys_clk);
    pin_req <= 1'b0;
    settle();
    chk(ldo_code[4:0], 5'h1F);
  endtask

  task automatic t_float();
    wr(IDX_MODE_2, 16'h0400, RESP_OK);
    wr(IDX_ENABLE_A, 16'h0100, RESP_OK);
    settle();
    chk(ldo_discharge, 4'hC);
    rdr(IDX_STATUS);
    chk(rd, 32'h00000C01);
    wr(IDX_ENABLE_A, 16'h0000, RESP_OK);
    settle();
    chk(ldo_discharge, 4'hF);
  endtask

  task automatic t_bad();
    rdr(10'h040);
    chk({rs, rd}, {RESP_ERR, 32'h0});
    wr(10'h040, 16'hFFFF, RESP_ERR);
  endtask

  initial begin
    rst_n = 1'b0; awaddr = '0; araddr = '0; awvalid = 1'b0; wvalid = 1'b0;
    bready = 1'b0; arvalid = 1'b0; rready = 1'b0; wdata = '0; wstrb = 4'hF;
    lp_req = 3'h0; pin_req = 1'b0; n_fail = 0; num_checks = 0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    t_reset();
    t_alias();
    t_codes();
    t_switch();
    t_sleep();
    t_lines();
    t_pin();
    t_float();
    t_bad();
    stop_test();
  end

  // Whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    stop_test();
  end
endmodule
`default_nettype wire

// ===== verilog/ldoc_channel.sv
`default_nettype none
module ldoc_channel
  import ldoc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        enable,
  input  wire logic        switch_mode,
  input  wire logic        float_off,
  input  wire logic [4:0]  voltage_code,
  input  wire logic [4:0]  image_code,
  input  wire logic [1:0]  behaviour,
  input  wire logic [1:0]  source_select,
  input  wire logic        sleep_request_bit,
  input  wire logic [2:0]  low_power_request,
  input  wire logic        lowpower_pin_request,
  input  wire logic        all_off,
  output logic             on_next,
  output logic             reg_on,
  output logic             reg_switch,
  output logic             reg_discharge,
  output logic             reg_lowpower,
  output logic [4:0]       reg_code,
  output logic [11:0]      reg_mv
);
  wire       sel_req = (source_select == TRIG_SW) ? sleep_request_bit :
                       low_power_request[source_select - 2'h1];
  wire       lp      = sel_req | lowpower_pin_request;
  wire       use_img = lp & (behaviour == BEH_IMAGE);
  wire       go_off  = lp & (behaviour == BEH_OFF);
  wire [4:0] code_n  = use_img ? image_code : voltage_code;
  assign on_next = enable & ~go_off;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_on        <= 1'b0;
      reg_switch    <= 1'b0;
      reg_discharge <= 1'b1;
      reg_lowpower  <= 1'b0;
      reg_code      <= 5'h00;
      reg_mv        <= 12'h000;
    end else begin
      reg_on        <= on_next;
      reg_switch    <= on_next & switch_mode;
      reg_discharge <= ~on_next & (~float_off | all_off);
      reg_lowpower  <= lp;
      reg_code      <= code_n;
      reg_mv        <= (on_next & ~switch_mode) ? ldoc_code_mv(code_n) : 12'h000;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_SWITCH_NO_REG: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (enable && switch_mode && !go_off) |=> (reg_switch && reg_mv == 12'h000))
    else $error("switch mode still regulating");
  AST_TOP_CODE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (on_next && !switch_mode && code_n == 5'h1F) |=> (reg_mv == 12'hCE4))
    else $error("top code not 3300 mV");
  AST_IMAGE_SEL: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (lp && behaviour == BEH_IMAGE) |=> (reg_code == $past(image_code)))
    else $error("image code not applied");
  AST_SLEEP_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (lp && behaviour == BEH_OFF) |=> !reg_on)
    else $error("sleep disable ignored");
  AST_SOURCE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (source_select == 2'h2 && low_power_request[1]) |=> reg_lowpower)
    else $error("selected trigger not seen");
  AST_PIN_ALL: assert property (@(posedge sys_clk) disable iff (!rst_n)
    lowpower_pin_request |=> reg_lowpower)
    else $error("pin request ignored");
  AST_FLOAT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!on_next && float_off && !all_off) |=> !reg_discharge)
    else $error("float option not honoured");
  AST_ALL_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
    all_off |=> reg_discharge)
    else $error("all off but not discharging");
  AST_RETURN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!lp && enable) |=> (reg_on && reg_code == $past(voltage_code)))
    else $error("no return from low power");
endmodule
`default_nettype wire

// ===== verilog/ldoc_pkg.sv
`default_nettype none
package ldoc_pkg;
  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int          NUM_LDO  = 4;
  localparam int          REG_W    = 16;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_ENABLE_A  = 10'h00D;
  localparam logic [9:0] IDX_ENABLE_B  = 10'h0B0;
  localparam logic [9:0] IDX_MODE_1    = 10'h0C8;
  localparam logic [9:0] IDX_IMAGE_1   = 10'h0CA;
  localparam logic [9:0] IDX_MODE_2    = 10'h0CB;
  localparam logic [9:0] IDX_IMAGE_2   = 10'h0CD;
  localparam logic [9:0] IDX_MODE_3    = 10'h0CE;
  localparam logic [9:0] IDX_IMAGE_3   = 10'h0D0;
  localparam logic [9:0] IDX_MODE_4    = 10'h0D1;
  localparam logic [9:0] IDX_IMAGE_4   = 10'h0D3;
  localparam logic [9:0] IDX_SLEEP_CTL = 10'h0F0;
  localparam logic [9:0] IDX_STATUS    = 10'h0F1;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         POS_CODE     = 0;
  localparam int         POS_FLOAT    = 10;
  localparam int         POS_SWITCH   = 14;
  localparam int         POS_TRIG     = 8;
  localparam int         POS_BEH      = 12;
  localparam int         POS_ENABLE   = 8;
  localparam int         POS_SLEEP    = 0;
  localparam int         POS_ST_LP    = 4;
  localparam int         POS_ST_DIS   = 8;
  localparam logic [4:0] RST_IMAGE    = 5'h1C;
  localparam logic [1:0] RST_BEH      = 2'h0;
  localparam logic [1:0] RST_TRIG     = 2'h0;
  localparam logic [1:0] BEH_IMAGE    = 2'h0;
  localparam logic [1:0] BEH_OFF      = 2'h1;
  localparam logic [1:0] TRIG_SW      = 2'h0;

  // ----------------------------------------------------------------
  // Voltage encoding, millivolts
  // ----------------------------------------------------------------
  localparam logic [11:0] MV_LOW_BASE  = 12'h384;
  localparam logic [11:0] MV_LOW_STEP  = 12'h032;
  localparam logic [11:0] MV_HIGH_BASE = 12'h708;
  localparam logic [11:0] MV_HIGH_STEP = 12'h064;

  function automatic logic [11:0] ldoc_code_mv(input logic [4:0] code);
    logic [11:0] step;
    step = {8'h00, code[3:0]};
    if (code[4]) begin
      ldoc_code_mv = MV_HIGH_BASE + 12'(step * MV_HIGH_STEP);
    end else begin
      ldoc_code_mv = MV_LOW_BASE + 12'(step * MV_LOW_STEP);
    end
  endfunction
endpackage
`default_nettype wire

// ===== verilog/ldoc_top.sv
// How it works
// - Switch bit makes regulator an unregulated switch
// - Code maps 0.9V/50mV low, 1.8V/100mV high
// - New voltage code applies immediately while running
// - Image code, reset 1C, used in low power
// - Sleep behaviour: image voltage or disable output
// - Trigger select: software bit or three lines
// - Low-power triggers are active high
// - Low-power pin forces all regulators low power
// - Float bit: discharge or float when disabled
// - All four disabled forces discharge everywhere
// - Enable bits reachable at two identical addresses
`default_nettype none
module ldoc_top
  import ldoc_pkg::*;
#(
  parameter int         ADDR_W     = 12,
  parameter logic [4:0] VSEL_RESET = 5'h00
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [2:0]        low_power_request,
  input  wire logic              lowpower_pin_request,
  output logic [3:0]             ldo_on,
  output logic [3:0]             ldo_switch,
  output logic [3:0]             ldo_discharge,
  output logic [19:0]            ldo_code,
  output logic [47:0]            ldo_mv
);
  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < 12) begin : g_bad_addr
    $error("ADDR_W must be at least 12");
  end

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  logic [4:0]        vsel  [NUM_LDO];
  logic [4:0]        vimg  [NUM_LDO];
  logic [1:0]        beh   [NUM_LDO];
  logic [1:0]        trig  [NUM_LDO];
  logic [3:0]        swi;
  logic [3:0]        flt;
  logic [3:0]        en;
  logic              sleep_bit;
  logic [3:0]        lp_state;
  logic [3:0]        on_next;
  logic [ADDR_W-1:0] aw_addr;
  logic [15:0]       w_data;
  logic [1:0]        w_strb;

  localparam logic [9:0] IDX_MODE  [NUM_LDO] = '{IDX_MODE_1, IDX_MODE_2,
                                                 IDX_MODE_3, IDX_MODE_4};
  localparam logic [9:0] IDX_IMAGE [NUM_LDO] = '{IDX_IMAGE_1, IDX_IMAGE_2,
                                                 IDX_IMAGE_3, IDX_IMAGE_4};

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  strb);
    merge16 = {strb[1] ? new_v[15:8] : old_v[15:8],
               strb[0] ? new_v[7:0]  : old_v[7:0]};
  endfunction

  function automatic logic is_enable_idx(input logic [9:0] idx);
    is_enable_idx = (idx == IDX_ENABLE_A) || (idx == IDX_ENABLE_B);
  endfunction

  // ----------------------------------------------------------------
  // Write path decode
  // ----------------------------------------------------------------
  wire [9:0]  wr_idx   = aw_addr[11:2];
  wire        wr_high  = (aw_addr[ADDR_W-1:2] >> 10) != '0;
  wire        do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire        wr_en    = do_write && !wr_high && is_enable_idx(wr_idx);
  wire        wr_sleep = do_write && !wr_high && (wr_idx == IDX_SLEEP_CTL);
  wire [15:0] en_word  = {4'h0, en, 8'h00};
  wire [15:0] en_merge = merge16(en_word, w_data, w_strb);
  wire [15:0] sl_merge = merge16({15'h0000, sleep_bit}, w_data, w_strb);
  logic [3:0] wr_mode;
  logic [3:0] wr_image;
  logic [3:0] rd_hit_mode;
  logic [3:0] rd_hit_image;

  // ----------------------------------------------------------------
  // Read path decode
  // ----------------------------------------------------------------
  wire [9:0]  rd_idx  = s_axi_araddr[11:2];
  wire        rd_high = (s_axi_araddr[ADDR_W-1:2] >> 10) != '0;
  logic [15:0] mode_word  [NUM_LDO];
  logic [15:0] image_word [NUM_LDO];
  logic [15:0] rd_mode_sel;
  logic [15:0] rd_image_sel;
  wire [15:0] status_word = {4'h0, ldo_discharge, lp_state, ldo_on};
  wire        rd_en_hit   = is_enable_idx(rd_idx);
  wire        rd_sl_hit   = rd_idx == IDX_SLEEP_CTL;
  wire        rd_st_hit   = rd_idx == IDX_STATUS;
  wire        rd_ok       = !rd_high && (rd_en_hit || rd_sl_hit || rd_st_hit ||
                                         (|rd_hit_mode) || (|rd_hit_image));
  wire [15:0] rd_word     = rd_en_hit ? en_word :
                            rd_sl_hit ? {15'h0000, sleep_bit} :
                            rd_st_hit ? status_word :
                            (|rd_hit_mode) ? rd_mode_sel : rd_image_sel;
  wire        wr_ok       = !wr_high && (is_enable_idx(wr_idx) ||
                            (wr_idx == IDX_SLEEP_CTL) || (wr_idx == IDX_STATUS) ||
                            (|wr_mode) || (|wr_image));

  always_comb begin
    rd_mode_sel  = 16'h0000;
    rd_image_sel = 16'h0000;
    for (int i = 0; i < NUM_LDO; i++) begin
      if (rd_hit_mode[i]) begin
        rd_mode_sel = mode_word[i];
      end
      if (rd_hit_image[i]) begin
        rd_image_sel = image_word[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-regulator registers and output logic
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_LDO; i++) begin : g_ldo
    wire [15:0] m_new = merge16(mode_word[i], w_data, w_strb);
    wire [15:0] i_new = merge16(image_word[i], w_data, w_strb);
    assign wr_mode[i]      = do_write && !wr_high && (wr_idx == IDX_MODE[i]);
    assign wr_image[i]     = do_write && !wr_high && (wr_idx == IDX_IMAGE[i]);
    assign rd_hit_mode[i]  = rd_idx == IDX_MODE[i];
    assign rd_hit_image[i] = rd_idx == IDX_IMAGE[i];
    assign mode_word[i]    = {1'b0, swi[i], 3'h0, flt[i], 5'h00, vsel[i]};
    assign image_word[i]   = {2'h0, beh[i], 2'h0, trig[i], 3'h0, vimg[i]};

    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        vsel[i] <= VSEL_RESET;
        swi[i]  <= 1'b0;
        flt[i]  <= 1'b0;
      end else if (wr_mode[i]) begin
        vsel[i] <= m_new[POS_CODE +: 5];
        swi[i]  <= m_new[POS_SWITCH];
        flt[i]  <= m_new[POS_FLOAT];
      end
    end

    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        vimg[i] <= RST_IMAGE;
        beh[i]  <= RST_BEH;
        trig[i] <= RST_TRIG;
      end else if (wr_image[i]) begin
        vimg[i] <= i_new[POS_CODE +: 5];
        beh[i]  <= i_new[POS_BEH +: 2];
        trig[i] <= i_new[POS_TRIG +: 2];
      end
    end

    ldoc_channel u_channel (
      .sys_clk              (sys_clk),
      .rst_n                (rst_n),
      .enable               (en[i]),
      .switch_mode          (swi[i]),
      .float_off            (flt[i]),
      .voltage_code         (vsel[i]),
      .image_code           (vimg[i]),
      .behaviour            (beh[i]),
      .source_select        (trig[i]),
      .sleep_request_bit    (sleep_bit),
      .low_power_request    (low_power_request),
      .lowpower_pin_request (lowpower_pin_request),
      .all_off              (~|on_next),
      .on_next              (on_next[i]),
      .reg_on               (ldo_on[i]),
      .reg_switch           (ldo_switch[i]),
      .reg_discharge        (ldo_discharge[i]),
      .reg_lowpower         (lp_state[i]),
      .reg_code             (ldo_code[i*5 +: 5]),
      .reg_mv               (ldo_mv[i*12 +: 12])
    );
  end

  // ----------------------------------------------------------------
  // Shared enable and software sleep registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      en        <= 4'h0;
      sleep_bit <= 1'b0;
    end else begin
      if (wr_en) begin
        en <= en_merge[POS_ENABLE +: 4];
      end
      if (wr_sleep) begin
        sleep_bit <= sl_merge[POS_SLEEP];
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Address and data are held until both arrived, so either order works
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OK;
      aw_addr       <= '0;
      w_data        <= 16'h0000;
      w_strb        <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data       <= s_axi_wdata[15:0];
        w_strb       <= s_axi_wstrb[1:0];
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OK : RESP_ERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OK;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_ok ? {16'h0000, rd_word} : 32'h0000_0000;
        s_axi_rresp   <= rd_ok ? RESP_OK : RESP_ERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_EN_ALIAS_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (do_write && !wr_high && wr_idx == IDX_ENABLE_B && w_strb[1])
      |=> (en == $past(w_data[11:8])))
    else $error("alias enable write lost");
  AST_RD_ONE_CYCLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_axi_arvalid && s_axi_arready) |=> (s_axi_rvalid && !s_axi_arready))
    else $error("read answer late");
  AST_WR_RESP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
      |=> ##1 s_axi_bvalid)
    else $error("write response missing");
  AST_DISCHARGE_ALL: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (on_next == 4'h0) |=> (ldo_discharge == 4'hF))
    else $error("all off but some output floats");
  AST_VSEL_LIVE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_mode[0] && lp_state[0] == 1'b0 && !lowpower_pin_request &&
     trig[0] == TRIG_SW && !sleep_bit) |=> ##1 (ldo_code[4:0] == $past(vsel[0]))
    )
    else $error("voltage code not applied");
endmodule
`default_nettype wire
